//--- bod_pkg.sv
// Package holding the bank A control map, reset values and the ratio table
package bod_pkg;
   localparam logic [7:0] ADDR_RATIO    = 8'h10;
   localparam logic [7:0] ADDR_RSVD_11  = 8'h11;
   localparam logic [7:0] ADDR_PWR_SRC  = 8'h12;
   localparam logic [7:0] ADDR_RSVD_13  = 8'h13;
   localparam logic [7:0] ADDR_OUT_PD0  = 8'h14;
   localparam logic [7:0] ADDR_OUT_PD3  = 8'h17;
   localparam int         NUM_OUTPUTS   = 4;
   localparam int         RATIO_LSB     = 0;
   localparam int         RATIO_W       = 6;
   localparam int         BANK_PD_BIT   = 7;
   localparam int         SRC_BIT       = 0;
   localparam int         OUT_PD_BIT    = 7;
   localparam logic [5:0] RATIO_RESET   = 6'h0d;
   localparam logic       BANK_PD_RESET = 1'h0;
   localparam logic       SRC_RESET     = 1'h0;
   localparam logic       OUT_PD_RESET  = 1'h0;
   localparam logic       SRC_PINS      = 1'h0;
   localparam logic       SRC_REGS      = 1'h1;
   // Strap decode: pin value selects a code; the top value powers the bank down
   localparam logic [5:0] STRAP_CODE [0:3] = '{6'h0d, 6'h07, 6'h17, 6'h0d};
   localparam logic [1:0] STRAP_PD_VAL  = 2'h3;
   // Divide ratio per code, zero where the code is reserved
   localparam logic [7:0] RATIO_TABLE [0:63] = '{
      8'h00, 8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
      8'h09, 8'h0a, 8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h12, 8'h14,
      8'h15, 8'h16, 8'h18, 8'h19, 8'h1b, 8'h1c, 8'h1e, 8'h20,
      8'h21, 8'h23, 8'h24, 8'h28, 8'h2a, 8'h2c, 8'h2d, 8'h30,
      8'h32, 8'h36, 8'h37, 8'h38, 8'h3c, 8'h40, 8'h42, 8'h46,
      8'h48, 8'h50, 8'h54, 8'h58, 8'h5a, 8'h60, 8'h64, 8'h6c,
      8'h6e, 8'h70, 8'h78, 8'h80, 8'h84, 8'h8c, 8'h90, 8'ha0,
      8'hb0, 8'hb4, 8'hc8, 8'hdc, 8'h00, 8'h00, 8'h00, 8'h00};

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bod_reg_req_t;
endpackage

//--- bod_bank_ctrl.sv
// Bank A output divider control registers with pin or register source
//
// Overview of operation
// - Decode six-bit code through fixed ratio table
// - New ratio waits for init-bit toggle
// - Bank power-down bit powers down whole bank when source is one
// - Source zero: straps give ratio and power
// - Source one: registers give ratio and power
// - Each output has its own power-down bit
// - Reserved bits written zero, read zero
// - Source, bank and output bits reset zero
`timescale 1ns/100ps
module bod_bank_ctrl
#(
   // Outputs in the bank, one address each
   parameter int OUT_COUNT = bod_pkg::NUM_OUTPUTS
)
(
   // Clock and reset
   input  wire logic                              ref_clk_in,
   input  wire logic                              rst_n_in,
   // Register access from the serial interface engine
   input  wire bod_pkg::bod_reg_req_t             reg_req_in,
   output logic [7:0]                             reg_rdata_out,
   // Clock-initialisation bit and strap pins
   input  wire logic                              init_clk_in,
   input  wire logic [1:0]                        bank_strap_pins_in,
   // Bank controls
   output logic [5:0]                             active_code_out,
   output logic [7:0]                             divide_ratio_out,
   output logic                                   code_reserved_out,
   output logic                                   bank_power_down_out,
   output logic [OUT_COUNT-1:0]                   output_power_down_out
);
   import bod_pkg::*;

   // Span of the output power-down addresses
   localparam int OUT_SPAN = int'(ADDR_OUT_PD3 - ADDR_OUT_PD0) + 1;

   logic [5:0]             bank_divider_ratio;
   logic                   bank_power_down;
   logic                   bank_config_source;
   logic [OUT_COUNT-1:0]   output_power_down;
   logic [1:0]             strap_meta;
   logic [1:0]             strap_sync;
   logic                   init_prev;
   logic                   init_toggle;
   logic [5:0]             sel_code;
   logic                   sel_pd;
   logic [5:0]             next_active;
   logic [1:0]             out_idx;
   logic                   out_hit;
   logic                   ratio_wr;
   logic                   pwr_src_wr;
   logic [OUT_COUNT-1:0]   out_wr;

   // Each output owns one address of the window
   if (OUT_COUNT != OUT_SPAN)
   begin : bad_out_count
      $error("output count must fill the output address window");
   end

   // Either edge of the init bit is a toggle
   assign init_toggle = init_clk_in ^ init_prev;
   assign out_hit     = reg_req_in.addr >= ADDR_OUT_PD0 && reg_req_in.addr <= ADDR_OUT_PD3;
   assign out_idx     = reg_req_in.addr[1:0];

   // One write strobe per register
   assign ratio_wr    = reg_req_in.wr && reg_req_in.addr == ADDR_RATIO;
   assign pwr_src_wr  = reg_req_in.wr && reg_req_in.addr == ADDR_PWR_SRC;
   for (genvar k = 0; k < OUT_COUNT; k++)
   begin : out_dec
      assign out_wr[k] = reg_req_in.wr && out_hit && out_idx == 2'(k);
   end

   // Strap pins pass two flops before use
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         strap_meta <= 2'h0;
         strap_sync <= 2'h0;
      end
      else
      begin
         strap_meta <= bank_strap_pins_in;
         strap_sync <= strap_meta;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         bank_divider_ratio <= RATIO_RESET;
      else if (ratio_wr)
         bank_divider_ratio <= reg_req_in.wdata[RATIO_LSB +: RATIO_W];
   end

   // bank and source bits reset zero
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         bank_power_down    <= BANK_PD_RESET;
         bank_config_source <= SRC_RESET;
      end
      else if (pwr_src_wr)
      begin
         bank_power_down    <= reg_req_in.wdata[BANK_PD_BIT];
         bank_config_source <= reg_req_in.wdata[SRC_BIT];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         output_power_down <= {OUT_COUNT{OUT_PD_RESET}};
      else
      begin
         for (int k = 0; k < OUT_COUNT; k++)
         begin
            if (out_wr[k])
               output_power_down[k] <= reg_req_in.wdata[OUT_PD_BIT];
         end
      end
   end

   // Read data holds until the next read
   // Read data, reserved and unmapped bits read zero
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         reg_rdata_out <= 8'h00;
      else if (reg_req_in.rd)
      begin
         if (reg_req_in.addr == ADDR_RATIO)
            reg_rdata_out <= {2'h0, bank_divider_ratio};
         else if (reg_req_in.addr == ADDR_PWR_SRC)
            reg_rdata_out <= {bank_power_down, 6'h00, bank_config_source};
         else if (out_hit)
            reg_rdata_out <= {output_power_down[out_idx], 7'h00};
         else
            reg_rdata_out <= 8'h00;
      end
   end

   // Source bit picks straps or registers
   // pins drive ratio and power state
   // registers drive ratio and power state
   always_comb
   begin
      if (bank_config_source == SRC_REGS)
      begin
         sel_code = bank_divider_ratio;
         sel_pd   = bank_power_down;
      end
      else
      begin
         sel_code = STRAP_CODE[strap_sync];
         sel_pd   = (strap_sync == STRAP_PD_VAL);
      end
   end

   // Strap code waits for the toggle too, no divider slip
   // active code changes only on toggle
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         init_prev   <= 1'h0;
         next_active <= RATIO_RESET;
      end
      else
      begin
         init_prev <= init_clk_in;
         if (init_toggle)
            next_active <= sel_code;
      end
   end

   // Reserved codes decode to zero and raise a flag
   // table decode of the active code
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         active_code_out   <= RATIO_RESET;
         divide_ratio_out  <= RATIO_TABLE[RATIO_RESET];
         code_reserved_out <= 1'h0;
      end
      else
      begin
         active_code_out   <= next_active;
         divide_ratio_out  <= RATIO_TABLE[next_active];
         code_reserved_out <= (RATIO_TABLE[next_active] == 8'h00);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         bank_power_down_out   <= 1'h0;
         output_power_down_out <= {OUT_COUNT{1'h0}};
      end
      else
      begin
         bank_power_down_out   <= sel_pd;
         output_power_down_out <= output_power_down | {OUT_COUNT{sel_pd}};
      end
   end
endmodule

//--- bod_bank_chk.sv
// Assertion checker for the bank A control ports
`timescale 1ns/100ps
module bod_bank_chk
(
   input wire logic                          ref_clk_in,
   input wire logic                          rst_n_in,
   input wire bod_pkg::bod_reg_req_t         reg_req_in,
   input wire logic [7:0]                    reg_rdata_out,
   input wire logic                          init_clk_in,
   input wire logic [1:0]                    bank_strap_pins_in,
   input wire logic [5:0]                    active_code_out,
   input wire logic [7:0]                    divide_ratio_out,
   input wire logic                          code_reserved_out,
   input wire logic                          bank_power_down_out,
   input wire logic [bod_pkg::NUM_OUTPUTS-1:0] output_power_down_out
);
   import bod_pkg::*;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   ratio_table_a: assert property (divide_ratio_out == RATIO_TABLE[active_code_out])
      else $error("ratio differs from code");
   code_hold_a: assert property ($stable(init_clk_in) && $past(init_clk_in) ==
      $past(init_clk_in, 2) |=> $stable(active_code_out)) else $error("code moved alone");
   bank_outs_a: assert property (bank_power_down_out |-> &output_power_down_out)
      else $error("output up in a downed bank");
   reset_vals_a: assert property ($rose(rst_n_in) |-> active_code_out == RATIO_RESET
      && !bank_power_down_out && output_power_down_out == '0) else $error("bad reset state");
   rsvd_read_a: assert property (reg_req_in.rd && reg_req_in.addr == ADDR_RSVD_11
      |=> reg_rdata_out == 8'h00) else $error("reserved address read nonzero");
   ratio_back_a: assert property (reg_req_in.wr && reg_req_in.addr == ADDR_RATIO ##2
      reg_req_in.rd && reg_req_in.addr == ADDR_RATIO |=>
      reg_rdata_out == {2'h0, $past(reg_req_in.wdata[5:0], 3)}) else $error("bad readback");
   src_pd_a: assert property (reg_req_in.wr && reg_req_in.addr == ADDR_PWR_SRC &&
      reg_req_in.wdata[SRC_BIT] ##1 1'b1 |=> bank_power_down_out ==
      $past(reg_req_in.wdata[BANK_PD_BIT], 2)) else $error("bank state not from register");
   out_pd_a: assert property (reg_req_in.wr && reg_req_in.addr == ADDR_OUT_PD0 &&
      !bank_power_down_out ##1 !bank_power_down_out |=> output_power_down_out[0] ==
      $past(reg_req_in.wdata[OUT_PD_BIT], 2)) else $error("output bit not applied");
   cover property (init_clk_in != $past(init_clk_in));
   cover property (bank_power_down_out);
   cover property (code_reserved_out);
endmodule
bind bod_bank_ctrl bod_bank_chk chk (.ref_clk_in, .rst_n_in, .reg_req_in, .reg_rdata_out,
   .init_clk_in, .bank_strap_pins_in, .active_code_out, .divide_ratio_out,
   .code_reserved_out, .bank_power_down_out, .output_power_down_out);

//--- bod_host.sv
// Host processor model issuing register transfers
`timescale 1ns/100ps
module bod_host
(
   input  wire logic            ref_clk_in,
   output bod_pkg::bod_reg_req_t req_out,
   input  wire logic [7:0]      rdata_in
);
   import bod_pkg::*;
   initial req_out = '0;
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge ref_clk_in);
      #1 req_out = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge ref_clk_in);
      #1 req_out = '0;
      q = rdata_in;
   endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the bank A divider control block
`timescale 1ns/100ps
module tb_top;
   import bod_pkg::*;
   logic         ref_clk_in, rst_n_in, init_clk_in, rsvd, bank_pd;
   logic [1:0]   pins;
   logic [3:0]   out_pd, e;
   logic [5:0]   code;
   logic [7:0]   rdata, ratio, q, d, prev;
   bod_reg_req_t req;
   int           mismatches, tests_run, seed, i;
   logic [13:0]  pairs [0:4] = '{14'h0202, 14'h3bdc, 14'h2136, 14'h3c00, 14'h0d10};
   bod_bank_ctrl DUT (.ref_clk_in, .rst_n_in, .reg_req_in(req), .reg_rdata_out(rdata),
      .init_clk_in, .bank_strap_pins_in(pins), .active_code_out(code),
      .divide_ratio_out(ratio), .code_reserved_out(rsvd), .bank_power_down_out(bank_pd),
      .output_power_down_out(out_pd));
   bod_host host (.ref_clk_in, .req_out(req), .rdata_in(rdata));
   task automatic check(input string what, input logic [7:0] seen, exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Strap code: pins 1 and 2 pick 07h and 17h, others 0Dh
   function automatic logic [7:0] strap_exp(input logic [1:0] p);
      return (p == 2'h1) ? 8'h07 : (p == 2'h2) ? 8'h17 : 8'h0d;
   endfunction
   task automatic rd(input logic [7:0] a, exp);
      host.xfer(1'b0, a, 8'h00, q);
      check("register", q, exp);
   endtask
   task automatic wr(input logic [7:0] a, dd);
      host.xfer(1'b1, a, dd, q);
   endtask
   task automatic wait_edges(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic toggle;
      wait_edges(1);
      init_clk_in = !init_clk_in;
      wait_edges(3);
   endtask
   task automatic close_out;
      $display("tests_run %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = !ref_clk_in;
   end
   initial
   begin
      #100000;
      mismatches++;
      close_out;
   end
   initial
   begin
      seed = 74;
      rst_n_in = 1'b0;
      init_clk_in = 1'b0;
      pins = 2'h0;
      wait_edges(2);
      rst_n_in = 1'b1;
      check("code", {2'h0, code}, 8'h0d);
      check("ratio", ratio, 8'h10);
      rd(ADDR_RATIO, 8'h0d);
      rd(ADDR_PWR_SRC, 8'h00);
      for (i = 0; i < 4; i++) rd(ADDR_OUT_PD0 + 8'(i), 8'h00);
      wr(ADDR_RSVD_11, 8'h5a);
      rd(ADDR_RSVD_11, 8'h00);
      wr(ADDR_RATIO, 8'hff);
      rd(ADDR_RATIO, 8'h3f);
      $display("reset test done");
      wr(ADDR_PWR_SRC, 8'h01);
      prev = 8'h0d;
      for (i = 0; i < 5; i++)
      begin
         wr(ADDR_RATIO, {2'h0, pairs[i][13:8]});
         wait_edges(4);
         check("held code", {2'h0, code}, prev);
         toggle;
         prev = {2'h0, pairs[i][13:8]};
         check("code", {2'h0, code}, prev);
         check("ratio", ratio, pairs[i][7:0]);
         check("reserved", {7'h0, rsvd}, {7'h0, pairs[i][7:0] == 8'h00});
      end
      $display("divider test done");
      for (i = 0; i < 6; i++)
      begin
         d = 8'($random(seed));
         e = d[7] ? 4'hf : d[3:0];
         wr(ADDR_PWR_SRC, {d[7], 7'h01});
         for (int j = 0; j < 4; j++) wr(ADDR_OUT_PD0 + 8'(j), {e[j], 7'h00});
         wait_edges(1);
         check("bank pd", {7'h0, bank_pd}, {7'h0, d[7]});
         check("out pd", {4'h0, out_pd}, {4'h0, e});
      end
      $display("power test done");
      wr(ADDR_PWR_SRC, 8'h80);
      for (int j = 0; j < 4; j++) wr(ADDR_OUT_PD0 + 8'(j), 8'h00);
      for (i = 1; i < 4; i++)
      begin
         pins = 2'(i);
         wait_edges(4);
         check("strap pd", {7'h0, bank_pd}, {7'h0, i == 3});
         toggle;
         check("strap code", {2'h0, code}, strap_exp(pins));
      end
      check("strap down", {4'h0, out_pd}, 8'h0f);
      $display("strap test done");
      close_out;
   end
endmodule
